/* logic/host_bus_port.sv */
/*
 * Synchronous host port: RAM and register access, interrupt output in
 * pulse or level mode, transmit inhibit polarity per transceiver type.
 * Assumes the host runs on clk_in and keeps to the single-clock protocol.
 */
// How it works
// - Every host signal sampled and updated on rising clk_in only.
// - Back-to-back accesses every cycle, any length, no idle needed.
// - Write when chip select and write strobe are both high.
// - After a write, read data shows the word just written.
// - Pulse mode: interrupt output low for 62 clocks (496 ns) per event.
// - Level mode: interrupt output low until host reads register 6.
// - Read data shows addressed location one clock after address.
// - Same one-clock latency for RAM and register accesses.
// - Standard transceiver: transmit inhibit outputs active high.
// - Discrete transceiver: outputs are enables, high while transmitting and during reset.
`timescale 1ns/10ps
module host_bus_port
    import host_port_pkg::*;
#(
    parameter int RAM_AW = 10,
    parameter int CHANNELS = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Host bus
    input wire logic cs_in,
    input wire logic we_in,
    input wire logic reg_sel_in,
    input wire logic [host_port_pkg::ADDR_W-1:0] addr_in,
    input wire logic [host_port_pkg::DATA_W-1:0] wdata_in,
    output logic [host_port_pkg::DATA_W-1:0] rdata_out,
    // Interrupt
    input wire logic irq_event_in,
    input wire logic irq_mode_in,
    output logic irq_out_low,
    // Transceiver
    input wire logic standard_transceiver_select,
    input wire logic [CHANNELS-1:0] tx_active_in,
    output logic [CHANNELS-1:0] tx_inhibit_out
);
    import host_port_pkg::*;

    initial begin
        if (RAM_AW > ADDR_W || RAM_AW < 1 || CHANNELS < 1) begin
            $error("host_bus_port parameters out of range");
        end
    end

    localparam int CNT_W = $clog2(IRQ_PULSE_CYC + 1);
    localparam logic [CNT_W-1:0] PULSE_LEN = CNT_W'(IRQ_PULSE_CYC);

    typedef struct packed {
        logic [REG_COUNT-1:0][DATA_W-1:0] regs;
        logic [DATA_W-1:0] reg_rd;
        logic sel_reg;
        logic irq_low;
        logic irq_n;
        logic [CNT_W-1:0] pulse_cnt;
        logic [CHANNELS-1:0] tx_inh;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [DATA_W-1:0] ram_rd;
    logic ram_en;
    logic wr;
    logic rd;
    logic rd_irq_reg;

    assign wr = cs_in && we_in;
    assign rd = cs_in && !we_in;
    assign rd_irq_reg = rd && reg_sel_in && (addr_in == IRQ_STATUS_REG);
    assign ram_en = cs_in && !reg_sel_in;

    word_store #(
        .AW(RAM_AW),
        .DW(DATA_W),
        .DEPTH(1 << RAM_AW)
    ) u_ram (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .en_in(ram_en),
        .we_in(we_in),
        .addr_in(addr_in[RAM_AW-1:0]),
        .wdata_in(wdata_in),
        .rdata_out(ram_rd)
    );

    always_comb begin
        s_d = s_q;
        if (wr && reg_sel_in) begin
            s_d.regs[addr_in[4:0]] = wdata_in;
        end
        if (cs_in && reg_sel_in) begin
            s_d.sel_reg = 1'b1;
            s_d.reg_rd = we_in ? wdata_in : s_q.regs[addr_in[4:0]];
        end else if (cs_in) begin
            s_d.sel_reg = 1'b0;
        end
        if (s_q.pulse_cnt != '0) begin
            s_d.pulse_cnt = s_q.pulse_cnt - CNT_W'(1);
        end
        // level release on register 6 read
        if (irq_mode_in == IRQ_MODE_LEVEL && rd_irq_reg) begin
            s_d.irq_low = 1'b0;
        end
        // New event wins over a release in the same cycle
        if (irq_event_in) begin
            if (irq_mode_in == IRQ_MODE_PULSE) begin
                s_d.pulse_cnt = PULSE_LEN;
            end else begin
                s_d.irq_low = 1'b1;
            end
        end
        if (irq_mode_in == IRQ_MODE_PULSE) begin
            s_d.irq_low = s_d.pulse_cnt != '0;
        end
        s_d.irq_n = !s_d.irq_low;
        if (standard_transceiver_select) begin
            s_d.tx_inh = ~tx_active_in;
        end else begin
            s_d.tx_inh = tx_active_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.tx_inh <= '1;
            s_q.irq_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Mux after RAM register keeps latency at one clock
    assign rdata_out = s_q.sel_reg ? s_q.reg_rd : ram_rd;
    assign irq_out_low = s_q.irq_n;
    assign tx_inhibit_out = s_q.tx_inh;

    // Helper: previous cycle access
    logic prev_rd_ram;
    logic prev_wr;
    logic [DATA_W-1:0] prev_wdata;
    always_ff @(posedge clk_in) begin
        prev_wr <= wr && !rst_in;
        prev_rd_ram <= rd && !reg_sel_in && !rst_in;
        prev_wdata <= wdata_in;
    end

    sequence ev_pulse;
        irq_event_in && irq_mode_in == IRQ_MODE_PULSE;
    endsequence

    sequence ev_level;
        irq_event_in && irq_mode_in == IRQ_MODE_LEVEL;
    endsequence

    sequence ram_read;
        rd && !reg_sel_in;
    endsequence

    sequence reg_read;
        rd && reg_sel_in;
    endsequence

    sequence ram_write;
        wr && !reg_sel_in;
    endsequence

    sequence reg_write;
        wr && reg_sel_in;
    endsequence

    sequence idle_cyc;
        !cs_in;
    endsequence

    AST_WRITE_ECHO: assert property (
        @(posedge clk_in) disable iff (rst_in)
        wr |=> rdata_out == $past(wdata_in))
        else $error("write not echoed on read data");

    AST_PULSE_LOW: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ev_pulse ##1 (irq_mode_in == IRQ_MODE_PULSE && !irq_event_in)[*8]
        |-> !irq_out_low) else $error("pulse released early");

    AST_PULSE_END: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_q.pulse_cnt == CNT_W'(1) && !irq_event_in |=> irq_out_low)
        else $error("pulse not released");

    AST_LEVEL_REL: assert property (
        @(posedge clk_in) disable iff (rst_in)
        irq_mode_in == IRQ_MODE_LEVEL && rd_irq_reg && !irq_event_in
        |=> irq_out_low) else $error("level irq not released");

    AST_LEVEL_HOLD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        irq_mode_in == IRQ_MODE_LEVEL && !irq_out_low && !rd_irq_reg
        |=> !irq_out_low) else $error("level irq dropped without read");

    AST_STD_XCVR: assert property (
        @(posedge clk_in) disable iff (rst_in)
        standard_transceiver_select |=> tx_inhibit_out == ~$past(tx_active_in))
        else $error("standard inhibit polarity wrong");

    AST_DISC_XCVR: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !standard_transceiver_select |=> tx_inhibit_out == $past(tx_active_in))
        else $error("discrete enable polarity wrong");

    AST_REG_LAT: assert property (
        @(posedge clk_in) disable iff (rst_in)
        reg_read |=> rdata_out == $past(s_q.regs[addr_in[4:0]]))
        else $error("register read latency wrong");

    AST_IDLE_KEEP: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !cs_in && !irq_event_in && irq_mode_in == IRQ_MODE_LEVEL
        |=> $stable(s_q.irq_low) && $stable(s_q.regs)) else $error("idle");

    AST_ECHO_PREV: assert property (
        @(posedge clk_in) disable iff (rst_in)
        prev_wr |-> rdata_out == prev_wdata)
        else $error("write echo missing");

    AST_RAM_LAT: assert property (
        @(posedge clk_in) disable iff (rst_in)
        prev_rd_ram |-> rdata_out == $past(u_ram.mem_q[addr_in[RAM_AW-1:0]]))
        else $error("RAM read latency wrong");

    AST_RAM_B2B: assert property (
        @(posedge clk_in) disable iff (rst_in) ram_read ##1 ram_read
        |=> rdata_out == $past(u_ram.mem_q[addr_in[RAM_AW-1:0]]))
        else $error("back-to-back read wrong");

    AST_WR_B2B: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ram_write ##1 ram_write |=> rdata_out == $past(wdata_in))
        else $error("back-to-back write wrong");

    AST_RAM_STORE: assert property (
        @(posedge clk_in) disable iff (rst_in) ram_write
        |=> u_ram.mem_q[$past(addr_in[RAM_AW-1:0])] == $past(wdata_in))
        else $error("RAM write not stored");

    AST_REG_STORE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        reg_write |=> s_q.regs[$past(addr_in[4:0])] == $past(wdata_in))
        else $error("register write not stored");

    AST_REG_KEEP: assert property (
        @(posedge clk_in) disable iff (rst_in)
        reg_read |=> $stable(s_q.regs))
        else $error("read changed registers");

    AST_IDLE_DATA: assert property (
        @(posedge clk_in) disable iff (rst_in)
        idle_cyc |=> $stable(rdata_out))
        else $error("idle cycle changed read data");

    AST_SEL_REG: assert property (
        @(posedge clk_in) disable iff (rst_in)
        reg_read |=> s_q.sel_reg)
        else $error("register path not selected");

    AST_SEL_RAM: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ram_read |=> !s_q.sel_reg)
        else $error("RAM path not selected");

    AST_PULSE_START: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ev_pulse |=> !irq_out_low)
        else $error("pulse did not start");

    AST_PULSE_LOAD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ev_pulse |=> s_q.pulse_cnt == PULSE_LEN)
        else $error("pulse timer not loaded");

    AST_PULSE_IDLE: assert property (
        @(posedge clk_in) disable iff (rst_in) irq_mode_in == IRQ_MODE_PULSE
        && s_q.pulse_cnt == '0 && !irq_event_in |=> irq_out_low)
        else $error("pulse low without event");

    AST_PULSE_COUNT: assert property (
        @(posedge clk_in) disable iff (rst_in) s_q.pulse_cnt != '0
        && !irq_event_in |=> s_q.pulse_cnt == $past(s_q.pulse_cnt) - 1'b1)
        else $error("pulse timer skipped");

    AST_LEVEL_SET: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ev_level |=> !irq_out_low)
        else $error("level irq not raised");

    AST_LEVEL_WINS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ev_level ##0 rd_irq_reg |=> !irq_out_low)
        else $error("release beat new event");

    AST_RESET_OUT: assert property (
        @(posedge clk_in) rst_in |=> irq_out_low
        && rdata_out == WORD_RESET && tx_inhibit_out == '1)
        else $error("outputs wrong after reset");

    AST_DISC_IDLE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !standard_transceiver_select && tx_active_in == '0
        |=> tx_inhibit_out == '0) else $error("discrete enable while idle");
endmodule

/* logic/host_port_pkg.sv */
/*
 * Constants shared by the synchronous host port.
 * Assumes a 125 MHz core clock feeding both the port and the host.
 */
package host_port_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int IRQ_PULSE_NS = 500;
    // Longest time: round down, never below one cycle
    localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (IRQ_PULSE_NS / CLK_PERIOD_NS);
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int REG_COUNT = 32;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_REG = 10'h006;
    localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
    localparam logic IRQ_MODE_PULSE = 1'b0;
    localparam logic IRQ_MODE_LEVEL = 1'b1;
endpackage

/* logic/word_store.sv */
/*
 * Flip-flop word store with one-clock registered read port.
 * Assumes a single clock; write and read share one address.
 */
`timescale 1ns/10ps
module word_store #(
    parameter int AW = 10,
    parameter int DW = 16,
    parameter int DEPTH = 1024
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Access
    input wire logic en_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DW-1:0] wdata_in,
    output logic [DW-1:0] rdata_out
);
    initial begin
        if (DEPTH > (1 << AW) || DEPTH < 1) begin
            $error("word_store depth does not fit address width");
        end
    end

    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] rd_q;
    assign rdata_out = rd_q;

    // Write-through: a written word is seen on the read port next cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_q <= '0;
        end else if (en_in) begin
            if (we_in) begin
                mem_q[addr_in] <= wdata_in;
                rd_q <= wdata_in;
            end else begin
                rd_q <= mem_q[addr_in];
            end
        end
    end
endmodule

/* sim/host_model.sv */
/*
 * Host-side user logic model that drives the port's bus.
 * Assumes clk_in is the very clock that feeds the port.
 */
`timescale 1ns/10ps
module host_model
    import host_port_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Host bus
    output logic cs_out,
    output logic we_out,
    output logic reg_sel_out,
    output logic [host_port_pkg::ADDR_W-1:0] addr_out,
    output logic [host_port_pkg::DATA_W-1:0] wdata_out
);
    initial begin
        cs_out = 1'h0;
        we_out = 1'h0;
        reg_sel_out = 1'h0;
        addr_out = '0;
        wdata_out = '0;
    end
    task automatic acc(input logic c, input logic w, input logic rs,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        #1;
        cs_out = c;
        we_out = w;
        reg_sel_out = rs;
        addr_out = a;
        wdata_out = d;
    endtask
    // Released address and data lines flip, so a stale value is never read as good
    task automatic idle();
        acc(1'h0, we_out, reg_sel_out, ~addr_out, ~wdata_out);
    endtask
endmodule

/* sim/tb_synchronous_host_bus_port.sv */
/*
 * Self-checking bench for the host port: bursts, registers, interrupt
 * modes and transmit inhibit polarity.
 * Assumes the host model and the port share clk_in.
 */
`timescale 1ns/10ps
module tb_synchronous_host_bus_port;
    import host_port_pkg::*;
    logic clk_in, rst_in, cs, we, rs, ev, mode, std;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, pend;
    logic [1:0] txa, txi;
    logic irq_n, have;
    int num_errors, n_compared, cycles, lows;
    logic [ADDR_W-1:0] a [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
    logic [DATA_W-1:0] d [4] = '{16'hA5A5, 16'h5A5A, 16'hFFFF, 16'h0001};
    host_model u_host (.clk_in(clk_in), .cs_out(cs), .we_out(we),
        .reg_sel_out(rs), .addr_out(addr), .wdata_out(wdata));
    host_bus_port u_dut (.clk_in(clk_in), .rst_in(rst_in), .cs_in(cs),
        .we_in(we), .reg_sel_in(rs), .addr_in(addr), .wdata_in(wdata),
        .rdata_out(rdata), .irq_event_in(ev), .irq_mode_in(mode),
        .irq_out_low(irq_n), .standard_transceiver_select(std),
        .tx_active_in(txa), .tx_inhibit_out(txi));
    initial begin
        clk_in = 1'h0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic chk(input string nm, input logic [DATA_W-1:0] e,
        input logic [DATA_W-1:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Access, then judge the one before it
    task automatic go(input logic c, input logic w, input logic r,
        input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd,
        input logic [DATA_W-1:0] e);
        u_host.acc(c, w, r, ad, wd);
        if (have) chk("rdata", pend, rdata);
        pend = e;
        have = 1'h1;
    endtask
    task automatic fin();
        u_host.idle();
        chk("rdata", pend, rdata);
        have = 1'h0;
    endtask
    task automatic pulse_ev();
        @(posedge clk_in);
        #1 ev = 1'h1;
        @(posedge clk_in);
        #1 ev = 1'h0;
    endtask
    task automatic t_bursts();
        for (int i = 0; i < 4; i++) go(1, 1, 0, a[i], d[i], d[i]);
        for (int i = 0; i < 4; i++) go(1, 0, 0, a[i], '0, d[i]);
        fin();
        go(1, 1, 0, a[0], 16'h1234, 16'h1234);
        u_host.acc(0, 1, 0, a[0], 16'hDEAD);
        chk("rdata", 16'h1234, rdata);
        have = 1'h0;
        go(1, 0, 0, a[0], '0, 16'h1234);
        go(1, 1, 1, 10'h003, 16'hBEEF, 16'hBEEF);
        go(1, 0, 1, 10'h003, '0, 16'hBEEF);
        fin();
        $display("test bursts done");
    endtask
    task automatic t_irq();
        mode = IRQ_MODE_PULSE;
        pulse_ev();
        lows = 0;
        for (int i = 0; i < 100; i++) begin
            lows += !irq_n;
            @(posedge clk_in);
            #1;
        end
        chk("pulse cycles", DATA_W'(IRQ_PULSE_CYC), DATA_W'(lows));
        mode = IRQ_MODE_LEVEL;
        pulse_ev();
        repeat (80) @(posedge clk_in);
        #1 chk("irq level", '0, DATA_W'(irq_n));
        go(1, 1, 1, IRQ_STATUS_REG, 16'h0006, 16'h0006);
        u_host.acc(0, 0, 1, IRQ_STATUS_REG, '0);
        chk("rdata", pend, rdata);
        have = 1'h0;
        u_host.idle();
        chk("irq held", '0, DATA_W'(irq_n));
        go(1, 0, 1, IRQ_STATUS_REG, '0, 16'h0006);
        fin();
        u_host.idle();
        chk("irq release", 16'h0001, DATA_W'(irq_n));
        $display("test irq done");
    endtask
    task automatic t_tx();
        logic [1:0] ex;
        for (int s = 0; s < 2; s++) for (int v = 0; v < 4; v++) begin
            @(posedge clk_in);
            #1 std = s[0];
            txa = v[1:0];
            ex = s[0] ? ~v[1:0] : v[1:0];
            repeat (2) @(posedge clk_in);
            #1 chk("tx", DATA_W'(ex), DATA_W'(txi));
        end
        $display("test tx done");
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        rst_in = 1'h1;
        ev = 1'h0;
        mode = 1'h0;
        std = 1'h1;
        txa = 2'h0;
        have = 1'h0;
        repeat (10) @(posedge clk_in);
        #1 chk("rst rdata", WORD_RESET, rdata);
        chk("rst irq", 16'h0001, DATA_W'(irq_n));
        chk("rst tx", 16'h0003, DATA_W'(txi));
        rst_in = 1'h0;
        $display("test reset done");
        t_bursts();
        t_irq();
        t_tx();
        end_sim();
    end
endmodule
